//--- rtl/opr_pkg.sv
// Constants and types for the output pin remap register bank.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register master.
package opr_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int NUM_REGS = 7;        // Mapping registers in the bank
    localparam int PINS = 14;           // Remappable pins 10 to 23
    localparam int FIRST_PIN = 10;      // Number of the lowest pin served
    localparam int SEL_W = 5;           // Selector width
    localparam int FUNC_N = 32;         // Peripheral function numbers
    localparam int EVEN_LSB = 0;        // Even pin selector, bits 4..0
    localparam int ODD_LSB = 8;         // Odd pin selector, bits 12..8
    localparam int SMALL_FIRST_REG = 3; // First register absent on 28-pin
    localparam int ADDR_W = 5;          // Byte address width of the bank
    localparam int DATA_W = 32;         // Bus data width
    localparam int STRB_W = 4;          // Byte enables
    localparam int EVEN_LANE = 0;       // Byte lane of the even selector
    localparam int ODD_LANE = 1;        // Byte lane of the odd selector

    // ------------------------------------------------------------------
    // Register offsets, one aligned word each
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MAP_10_11 = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_MAP_12_13 = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_MAP_14_15 = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_MAP_16_17 = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_MAP_18_19 = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_MAP_20_21 = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_MAP_22_23 = 5'h18;
    localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
        OFS_MAP_10_11, OFS_MAP_12_13, OFS_MAP_14_15, OFS_MAP_16_17,
        OFS_MAP_18_19, OFS_MAP_20_21, OFS_MAP_22_23};

    // ------------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [SEL_W-1:0] opr_sel_type;

endpackage

//--- rtl/opr_sel_if.sv
// Carrier between the register bank and its per-pin output muxes.
// Assumes every signal lives on the bank's clock.
`timescale 1ns/10ps
interface opr_sel_if;
    import opr_pkg::*;
    opr_sel_type sel [PINS];          // Selector per pin
    logic [PINS-1:0] present;         // Pin exists on this package
    logic [FUNC_N-1:0] periph;        // Peripheral outputs by number
    logic [PINS-1:0] pin;             // Registered pin levels

    modport bank (output sel, output present, output periph, input pin);
    modport mux (input sel, input present, input periph, output pin);
endinterface // opr_sel_if

//--- rtl/opr_pin_mux.sv
// One remappable pin: selects a peripheral output and registers it.
// Assumes the selector and peripheral outputs come from the same clock.
`timescale 1ns/10ps
module opr_pin_mux #(
    parameter int IDX = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    opr_sel_if.mux bus
);
    import opr_pkg::*;

    logic pin_r;   // Registered pin level
    logic pin_nxt; // Next pin level

    // ------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------
    // Absent pins are held low so nothing toggles behind a missing pad
    always_comb begin
        pin_nxt = 1'b0;
        if (bus.present[IDX]) begin
            pin_nxt = bus.periph[bus.sel[IDX]];
        end
    end

    // Register stage, so the pin never sees a decode glitch
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end

    assign bus.pin[IDX] = pin_r;
endmodule // opr_pin_mux

//--- rtl/opr_top.sv
// Output pin remap register bank behind an AXI4-Lite slave.
// Assumes peripheral outputs are synchronous to CLOCK_I.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module opr_top #(
    parameter bit SMALL_PKG = 1'b0 // Set for the 28-pin package
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic [opr_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [opr_pkg::DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [opr_pkg::STRB_W-1:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [opr_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [opr_pkg::DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [opr_pkg::FUNC_N-1:0] PERIPH_OUT_I,
    output logic [opr_pkg::PINS-1:0] REMAP_PIN_O
);
    import opr_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    opr_sel_type sel_r [PINS];       // Selector store
    opr_sel_type sel_nxt [PINS];
    logic awready_r, awready_nxt;    // Write address ready
    logic wready_r, wready_nxt;      // Write data ready
    logic aw_hold_r, aw_hold_nxt;    // Write address parked
    logic w_hold_r, w_hold_nxt;      // Write data parked
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [DATA_W-1:0] w_data_r, w_data_nxt;
    logic [STRB_W-1:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt;      // Write answer pending
    logic [1:0] bresp_r, bresp_nxt;
    logic arready_r, arready_nxt;    // Read address ready
    logic rvalid_r, rvalid_nxt;      // Read answer pending
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [NUM_REGS-1:0] reg_here;   // Register exists on this package

    opr_sel_if sel_bus ();           // Carrier to the pin muxes

    // ------------------------------------------------------------------
    // Package variant
    // ------------------------------------------------------------------
    // Fixed at build time, so no strap sampling is needed
    always_comb begin
        for (int r = 0; r < NUM_REGS; r++) begin
            reg_here[r] = !(SMALL_PKG && (r >= SMALL_FIRST_REG));
        end
    end

    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------
    // Returns the register index, or NUM_REGS for an unmapped address
    function automatic int reg_index(input logic [ADDR_W-1:0] addr);
        int idx;
        idx = NUM_REGS;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (addr == REG_OFS[r]) begin
                idx = r;
            end
        end
        return idx;
    endfunction

    // ------------------------------------------------------------------
    // Write channel and selector store
    // ------------------------------------------------------------------
    // Address and data are parked independently; the store updates in
    // the cycle both are present and the answer rises on that same edge
    always_comb begin
        int widx;
        logic do_write;
        widx = NUM_REGS;
        do_write = 1'b0;
        sel_nxt = sel_r;
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        // Answer leaves once the master takes it
        if (bvalid_r && S_AXI_BREADY_I) begin
            bvalid_nxt = 1'b0;
        end
        // Park the address
        if (S_AXI_AWVALID_I && awready_r) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = S_AXI_AWADDR_I;
        end
        // Park the data
        if (S_AXI_WVALID_I && wready_r) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = S_AXI_WDATA_I;
            w_strb_nxt = S_AXI_WSTRB_I;
        end
        do_write = aw_hold_nxt && w_hold_nxt && !bvalid_nxt;
        if (do_write) begin
            widx = reg_index(aw_addr_nxt);
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            if (widx >= NUM_REGS) begin
                // Unmapped address: refused, nothing stored
                bresp_nxt = RESP_SLVERR;
            end else if (reg_here[widx]) begin
                // Only the selector fields are stored; other bits drop
                if (w_strb_nxt[EVEN_LANE]) begin
                    sel_nxt[2*widx] =
                        w_data_nxt[EVEN_LSB +: SEL_W];
                end
                if (w_strb_nxt[ODD_LANE]) begin
                    sel_nxt[2*widx+1] =
                        w_data_nxt[ODD_LSB +: SEL_W];
                end
            end
            // An absent register accepts the write and ignores it
        end
        // Stop taking beats while an answer is waiting
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt = !w_hold_nxt && !bvalid_nxt;
    end

    // Write state registers
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            for (int p = 0; p < PINS; p++) begin
                sel_r[p] <= SEL_RST;
            end
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= DATA_ZERO;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            sel_r <= sel_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    // One read at a time; data are captured when the address is taken
    always_comb begin
        int ridx;
        ridx = NUM_REGS;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && S_AXI_RREADY_I) begin
            rvalid_nxt = 1'b0;
        end
        if (S_AXI_ARVALID_I && arready_r) begin
            ridx = reg_index(S_AXI_ARADDR_I);
            rvalid_nxt = 1'b1;
            rdata_nxt = DATA_ZERO;
            rresp_nxt = RESP_OKAY;
            if (ridx >= NUM_REGS) begin
                rresp_nxt = RESP_SLVERR;
            end else if (reg_here[ridx]) begin
                rdata_nxt[EVEN_LSB +: SEL_W] = sel_r[2*ridx];
                rdata_nxt[ODD_LSB +: SEL_W] = sel_r[2*ridx+1];
            end
            // Absent register reads as zero
        end
        arready_nxt = !rvalid_nxt;
    end

    // Read state registers
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= DATA_ZERO;
            rresp_r <= RESP_OKAY;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------------
    // Peripheral outputs share this clock, so no synchroniser is used
    assign sel_bus.periph = PERIPH_OUT_I;
    assign sel_bus.sel = sel_r;
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            sel_bus.present[p] = reg_here[p/2];
        end
    end

    // One registered mux per pin
    for (genvar g = 0; g < PINS; g++) begin : g_pin
        opr_pin_mux #(.IDX(g)) u_mux (
            .clk_i(CLOCK_I),
            .rst_i(RST_I),
            .bus(sel_bus.mux)
        );
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign S_AXI_AWREADY_O = awready_r;
    assign S_AXI_WREADY_O = wready_r;
    assign S_AXI_BVALID_O = bvalid_r;
    assign S_AXI_BRESP_O = bresp_r;
    assign S_AXI_ARREADY_O = arready_r;
    assign S_AXI_RVALID_O = rvalid_r;
    assign S_AXI_RDATA_O = rdata_r;
    assign S_AXI_RRESP_O = rresp_r;
    assign REMAP_PIN_O = sel_bus.pin;
endmodule // opr_top

//--- verif/opr_periph_model.sv
// Stand-in for the on-chip peripherals feeding the pin muxes.
// Assumes the bank's clock and its active-high reset.
`timescale 1ns/10ps
module opr_periph_model (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic [31:0] periph_o
);
    logic [31:0] periph_r; // One output per function number
    // --------------------------------------------------------------
    // Pattern step
    // --------------------------------------------------------------
    // Linear congruence flips many bits a cycle, so a wrong route shows
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            periph_r <= 32'h1234_5678;
        end else begin
            periph_r <= periph_r * 32'h0019_660d + 32'h3c6e_f35f;
        end
    end
    assign periph_o = periph_r;
endmodule // opr_periph_model

//--- verif/opr_top_monitor.sv
// Concurrent checks on the remap bank's bus and pin ports.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/10ps
module opr_top_monitor
    import opr_pkg::*;
#(
    parameter bit SMALL_PKG = 1'b0 // Mirrors the build variant
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [DATA_W-1:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [PINS-1:0] REMAP_PIN_O
);
    // --------------------------------------------------------------
    // Handshake steps
    // --------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence aw_w_s;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
            && S_AXI_WREADY_O;
    endsequence
    sequence ar_s;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence
    // Read of a register missing on the small package
    // Only aligned words count: an unaligned offset is refused instead
    wire logic absent_w = SMALL_PKG && S_AXI_ARADDR_I >= OFS_MAP_16_17
        && S_AXI_ARADDR_I <= OFS_MAP_22_23 && S_AXI_ARADDR_I[1:0] == 2'h0;
    b_answer_a: assert property (aw_w_s |=> S_AXI_BVALID_O)
        else $error("write answer missing");
    b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
        |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write answer dropped");
    r_answer_a: assert property (ar_s |=> S_AXI_RVALID_O)
        else $error("read answer missing");
    r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
        |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read answer dropped");
    unimpl_zero_a: assert property (S_AXI_RVALID_O
        |-> (S_AXI_RDATA_O & 32'hffff_e0e0) == DATA_ZERO)
        else $error("unimplemented bits set");
    absent_read_a: assert property (ar_s ##0 absent_w
        |=> S_AXI_RDATA_O == DATA_ZERO && S_AXI_RRESP_O == RESP_OKAY)
        else $error("absent register not zero");
    unmapped_rd_a: assert property (ar_s ##0 S_AXI_ARADDR_I > OFS_MAP_22_23
        |=> S_AXI_RRESP_O == RESP_SLVERR && S_AXI_RDATA_O == DATA_ZERO)
        else $error("unmapped read not refused");
    small_pins_a: assert property (SMALL_PKG
        |-> REMAP_PIN_O[PINS-1:6] == 8'h00)
        else $error("absent pin driven");
endmodule // opr_top_monitor
bind opr_top opr_top_monitor #(.SMALL_PKG(SMALL_PKG)) u_mon (.*);

//--- verif/opr_top_tb.sv
// Testbench: full and 28-pin builds side by side on one bus master.
// Assumes the peripheral model drives PERIPH_OUT_I of both builds.
`timescale 1ns/10ps
module opr_top_tb;
    import opr_pkg::*;
    logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0;
    logic arv = 1'h0, rry = 1'h0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, periph;
    logic [3:0] ws = 4'h0;
    logic awrdy [2], wrdy [2], bvld [2], arrdy [2], rvld [2];
    logic [1:0] brsp [2], rrsp [2];
    logic [31:0] rdat [2];
    logic [13:0] pin [2];
    opr_sel_type sel_t [PINS]; // Selector each pin should hold
    int n_fail = 0, n_checks = 0;
    always #10 clk = ~clk;
    opr_periph_model u_periph (.clk_i(clk), .rst_i(rst), .periph_o(periph));
    // --------------------------------------------------------------
    // Index 0 is the full build, index 1 the 28-pin build
    // --------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : gen_dut
        opr_top #(.SMALL_PKG(g == 1)) dut (.CLOCK_I(clk), .RST_I(rst),
            .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
            .S_AXI_AWREADY_O(awrdy[g]), .S_AXI_WDATA_I(wd),
            .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv),
            .S_AXI_WREADY_O(wrdy[g]), .S_AXI_BRESP_O(brsp[g]),
            .S_AXI_BVALID_O(bvld[g]), .S_AXI_BREADY_I(bry),
            .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
            .S_AXI_ARREADY_O(arrdy[g]), .S_AXI_RDATA_O(rdat[g]),
            .S_AXI_RRESP_O(rrsp[g]), .S_AXI_RVALID_O(rvld[g]),
            .S_AXI_RREADY_I(rry), .PERIPH_OUT_I(periph),
            .REMAP_PIN_O(pin[g]));
    end
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, e, input string m);
        n_checks++;
        if (got !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, e);
        end
    endtask
    // Answer is left waiting a cycle so the slave must hold it
    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] e);
        int n;
        awa <= a; wd <= d; ws <= s; awv <= 1'h1; wv <= 1'h1;
        for (n = 0; n < 50 && bvld[0] !== 1'h1; n++) begin
            @(posedge clk);
            if (awrdy[0] === 1'h1) awv <= 1'h0;
            if (wrdy[0] === 1'h1) wv <= 1'h0;
        end
        if (n >= 50) begin n_fail++; close_out(); end
        bry <= 1'h1;
        @(posedge clk);
        chk(32'(brsp[0]), 32'(e), "bresp");
        chk(32'(brsp[1]), 32'(e), "bresp small");
        bry <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e0, e1,
                      input logic [1:0] e);
        int n;
        ara <= a; arv <= 1'h1;
        for (n = 0; n < 50 && rvld[0] !== 1'h1; n++) begin
            @(posedge clk);
            if (arrdy[0] === 1'h1) arv <= 1'h0;
        end
        if (n >= 50) begin n_fail++; close_out(); end
        rry <= 1'h1;
        @(posedge clk);
        chk(rdat[0], e0, "rdata");
        chk(rdat[1], e1, "rdata small");
        chk(32'(rrsp[0]), 32'(e), "rresp");
        chk(32'(rrsp[1]), 32'(e), "rresp small");
        rry <= 1'h0;
        @(posedge clk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < NUM_REGS; i++) begin
            rd(REG_OFS[i], DATA_ZERO, DATA_ZERO, RESP_OKAY);
        end
    endtask
    task automatic t_unmapped;
        wr(5'h1c, 32'hffff_ffff, 4'hf, RESP_SLVERR);
        rd(5'h1c, DATA_ZERO, DATA_ZERO, RESP_SLVERR);
    endtask
    // All ones first, then a pattern with junk in the spare bits
    task automatic t_rw;
        logic [31:0] v;
        for (int i = 0; i < NUM_REGS; i++) begin
            wr(REG_OFS[i], 32'hffff_ffff, 4'hf, RESP_OKAY);
            v = (i < SMALL_FIRST_REG) ? 32'h0000_1f1f : DATA_ZERO;
            rd(REG_OFS[i], 32'h0000_1f1f, v, RESP_OKAY);
            v = {19'h0, sel_t[2 * i + 1], 3'h0, sel_t[2 * i]};
            wr(REG_OFS[i], v | 32'he0e0_e0e0, 4'hf, RESP_OKAY);
            rd(REG_OFS[i], v, (i < SMALL_FIRST_REG) ? v : DATA_ZERO,
               RESP_OKAY);
        end
    endtask
    // One byte lane at a time: the other selector must not move.
    // Lane 1 data carry a new even value, so a leaking strobe shows.
    task automatic t_strobe;
        logic [31:0] v;
        for (int l = 0; l < 2; l++) begin
            wr(OFS_MAP_10_11, 32'h0000_0203 + 32'(l), 4'h1 << l,
               RESP_OKAY);
            sel_t[l] = (l == 1) ? 5'h02 : 5'h03;
            v = {19'h0, sel_t[1], 3'h0, sel_t[0]};
            rd(OFS_MAP_10_11, v, v, RESP_OKAY);
        end
    endtask
    // Pin after edge e follows the peripheral value sampled at e
    task automatic t_pins;
        logic [31:0] p;
        logic [13:0] e;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            p = periph;
            #1;
            for (int k = 0; k < PINS; k++) e[k] = p[sel_t[k]];
            chk(32'(pin[0]), 32'(e), "pins");
            chk(32'(pin[1]), 32'(e & 14'h003f), "pins small");
        end
    endtask
    // Reset in mid-run: stored selectors and pin routing clear again
    task automatic t_rereset;
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_reset();
        for (int k = 0; k < PINS; k++) sel_t[k] = SEL_RST;
        t_pins();
    endtask
    initial begin
        for (int k = 0; k < PINS; k++) sel_t[k] = opr_sel_type'(5 * k + 7);
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_reset();
        t_unmapped();
        t_rw();
        t_strobe();
        t_pins();
        t_rereset();
        close_out();
    end
endmodule // opr_top_tb
